/* mbst_ctl_model.sv */
// Board test controller model that drives the test port pins.
`timescale 1ns/1ps
`default_nettype none

module mbst_ctl_model (
  input wire logic ref_clk_i,
  input wire logic tdo_i,
  input wire logic tdo_oe_n_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o
);
  // ----------------------------------------
  // Pins
  // ----------------------------------------
  // The board pulls the released output line high.
  wire tdo_seen = tdo_oe_n_i ? 1'b1 : tdo_i;
  // The test clock stands low between frames.
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end

  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // One 64 ns test clock: data is sampled just before the rise.
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o <= tms;
    tdi_o <= tdi;
    repeat (8) @(posedge ref_clk_i);
    tdo = tdo_seen;
    tck_o <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    tck_o <= 1'b0;
  endtask

  // Steps the controller with TMS bits taken LSB first.
  task automatic walk(input int n, input logic [7:0] tms);
    logic b;
    for (int i = 0; i < n; i++) tick(tms[i], 1'b0, b);
  endtask

  // Shifts LSB first, leaves through update into idle.
  task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
    dout = '0;
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    walk(2, 8'h01);
  endtask

  // Only the six defined codes are ever passed in here.
  task automatic ir(input logic [7:0] code, output logic [127:0] dout);
    walk(4, 8'h03);
    shift(8, code, dout);
  endtask

  task automatic dr(input int n, input logic [127:0] din, output logic [127:0] dout);
    walk(3, 8'h01);
    shift(n, din, dout);
  endtask
endmodule // mbst_ctl_model
`default_nettype wire

/* mbst_defines.vh */
// Constants for the memory boundary-scan test port: codes, sizes, cell positions and identity fields.
`ifndef MBST_DEFINES_VH
`define MBST_DEFINES_VH

// ----------------------------------------------------------------
// Register sizes
// ----------------------------------------------------------------
`define MBST_IR_W 8
`define MBST_BSR_W 113
`define MBST_ID_W 32

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define MBST_OP_EXTEST 8'h00
`define MBST_OP_IDCODE 8'h21
`define MBST_OP_SAMPLE 8'h05
`define MBST_OP_CLAMP 8'h07
`define MBST_OP_HIGHZ 8'h03
`define MBST_OP_BYPASS 8'hFF
// Value loaded by capture-IR; the two low bits are the fixed 01 pattern.
`define MBST_IR_CAPTURE 8'h01

// ----------------------------------------------------------------
// Identification layout
// ----------------------------------------------------------------
`define MBST_ORG_X9 2'h0
`define MBST_ORG_X18 2'h1
`define MBST_ORG_X36 2'h2
`define MBST_DENS_288 3'h0
`define MBST_DENS_576 3'h1
`define MBST_IO_COMMON 1'h0
`define MBST_IO_SEPARATE 1'h1
`define MBST_ID_PRESENT 1'h1

// ----------------------------------------------------------------
// Named scan positions, numbered from 1 at the output end
// ----------------------------------------------------------------
`define MBST_POS_WDCLK 1
`define MBST_POS_WDCLK_N 2
`define MBST_POS_CS_N 3
`define MBST_POS_REF_N 4
`define MBST_POS_WE_N 5
`define MBST_POS_ADDR_17 6
`define MBST_POS_ADDR_16 7
`define MBST_POS_ADDR_18 8
`define MBST_POS_ADDR_15 9
`define MBST_POS_RDCLK_UP 18
`define MBST_POS_RDCLK_UP_N 19

// Do-not-use cells per organisation, bit n-1 stands for position n.
`define MBST_UNUSED_X9 113'hC_C7FF_FE00
`define MBST_UNUSED_X18 113'hC_C199_9800
`define MBST_UNUSED_X36 113'h0

`endif

/* mbst_pin_sync.v */
// Two-stage synchroniser for a group of levels arriving from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module mbst_pin_sync #(
  parameter W = 1
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);

  reg [W-1:0] meta;

  // The first stage feeds only the second stage, never any logic.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule // mbst_pin_sync

`default_nettype wire

/* mbst_tap.v */
// Boundary-scan test port of the memory device: instruction decode, data registers and ring control.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_defines.vh"

module mbst_tap #(
  parameter [1:0] ORG = `MBST_ORG_X36,
  parameter [1:0] DIE_REV = 2'h0,
  parameter [2:0] DENSITY = `MBST_DENS_576,
  parameter [0:0] IO_TYPE = `MBST_IO_COMMON,
  // Identity fields below are arbitrary neutral values.
  parameter [1:0] FAMILY_CODE = 2'h2,
  parameter [7:0] PART_CODE = 8'h5A,
  parameter [10:0] VENDOR_CODE = 11'h2A5
) (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire tck_i,
  input wire tms_i,
  input wire tdi_i,
  output reg tdo_o,
  output wire tdo_oe_n_o,
  input wire write_data_clock_i,
  input wire write_data_clock_n_i,
  input wire chip_select_n_i,
  input wire refresh_n_i,
  input wire write_enable_n_i,
  input wire address_in_17_i,
  input wire address_in_16_i,
  input wire address_in_18_i,
  input wire address_in_15_i,
  input wire [`MBST_BSR_W-1:0] ring_in_i,
  output reg [`MBST_BSR_W-1:0] ring_drive_o,
  output reg ring_from_scan_o,
  output reg outputs_hiz_o,
  output reg [`MBST_IR_W-1:0] instruction_o
);

  // ----------------------------------------------------------------
  // Pin synchronisation and test clock edges
  // ----------------------------------------------------------------

  wire [2:0] jtag_sync;
  wire [`MBST_BSR_W-1:0] ring_sync;
  wire [8:0] named_sync;
  reg tck_last;
  wire tck_rise;
  wire tck_fall;

  // The test clock is sampled like any other pin; its edges become enables.
  mbst_pin_sync #(
    .W(3)
  ) u_jtag_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({tck_i, tms_i, tdi_i}),
    .sync_o(jtag_sync)
  );

  // The ring moves on the memory clock, so it is synchronised before capture.
  mbst_pin_sync #(
    .W(`MBST_BSR_W)
  ) u_ring_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i(ring_in_i),
    .sync_o(ring_sync)
  );

  mbst_pin_sync #(
    .W(9)
  ) u_named_sync (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .async_i({address_in_15_i, address_in_18_i, address_in_16_i, address_in_17_i, write_enable_n_i,
              refresh_n_i, chip_select_n_i, write_data_clock_n_i, write_data_clock_i}),
    .sync_o(named_sync)
  );

  // Edge detection reads only the second synchroniser stage and its delayed copy.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tck_last <= 1'b0;
    end else begin
      tck_last <= jtag_sync[2];
    end
  end

  assign tck_rise = jtag_sync[2] & ~tck_last;
  assign tck_fall = ~jtag_sync[2] & tck_last;

  // ----------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------

  wire st_tlr;
  wire st_cap_dr;
  wire st_sh_dr;
  wire st_upd_dr;
  wire st_cap_ir;
  wire st_sh_ir;
  wire st_upd_ir;

  mbst_tap_fsm u_fsm (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .step_i(tck_rise),
    .tms_i(jtag_sync[1]),
    .test_reset_o(st_tlr),
    .capture_dr_o(st_cap_dr),
    .shift_dr_o(st_sh_dr),
    .update_dr_o(st_upd_dr),
    .capture_ir_o(st_cap_ir),
    .shift_ir_o(st_sh_ir),
    .update_ir_o(st_upd_ir)
  );

  // ----------------------------------------------------------------
  // Instruction register and decode
  // ----------------------------------------------------------------

  reg [`MBST_IR_W-1:0] ir_shift;
  reg sel_bsr;
  reg sel_id;
  reg next_from_scan;
  reg next_hiz;

  // Shift stage captures 01 in its low bits; the live code follows at update.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ir_shift <= `MBST_IR_CAPTURE;
      instruction_o <= `MBST_OP_IDCODE;
    end else if (tck_rise) begin
      if (st_tlr) begin
        instruction_o <= `MBST_OP_IDCODE;
      end else if (st_cap_ir) begin
        ir_shift <= `MBST_IR_CAPTURE;
      end else if (st_sh_ir) begin
        ir_shift <= {jtag_sync[0], ir_shift[`MBST_IR_W-1:1]};
      end else if (st_upd_ir) begin
        instruction_o <= ir_shift;
      end
    end
  end

  // Reserved codes are not expected; they fall to the bypass path as the safe choice.
  always @* begin
    sel_bsr = 1'b0;
    sel_id = 1'b0;
    next_from_scan = 1'b0;
    next_hiz = 1'b0;
    case (instruction_o)
      `MBST_OP_EXTEST: sel_bsr = 1'b1;
      `MBST_OP_SAMPLE: sel_bsr = 1'b1;
      `MBST_OP_IDCODE: sel_id = 1'b1;
      `MBST_OP_CLAMP: next_from_scan = 1'b1;
      `MBST_OP_HIGHZ: next_hiz = 1'b1;
      `MBST_OP_BYPASS: sel_bsr = 1'b0;
      default: sel_bsr = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Identification value
  // ----------------------------------------------------------------

  wire [15:0] device_field;
  wire [`MBST_ID_W-1:0] id_value;

  // Device field keeps the family, I/O type and density bits in fixed places.
  assign device_field = {2'h0, FAMILY_CODE, IO_TYPE, DENSITY, PART_CODE};
  assign id_value = {DIE_REV, ORG, device_field, VENDOR_CODE, `MBST_ID_PRESENT};

  // ----------------------------------------------------------------
  // Boundary-scan capture image
  // ----------------------------------------------------------------

  wire [`MBST_BSR_W-1:0] unused_mask;
  reg [`MBST_BSR_W-1:0] ring_image;

  assign unused_mask = (ORG == `MBST_ORG_X9) ? `MBST_UNUSED_X9 :
                       (ORG == `MBST_ORG_X18) ? `MBST_UNUSED_X18 : `MBST_UNUSED_X36;

  // Fixed-function balls sit at the same cells in every organisation. Each
  // data ball brings its input and its drive on one and the same ring bit.
  always @* begin
    ring_image = ring_sync;
    ring_image[`MBST_POS_WDCLK-1] = named_sync[0];
    ring_image[`MBST_POS_WDCLK_N-1] = named_sync[1];
    ring_image[`MBST_POS_CS_N-1] = named_sync[2];
    ring_image[`MBST_POS_REF_N-1] = named_sync[3];
    ring_image[`MBST_POS_WE_N-1] = named_sync[4];
    ring_image[`MBST_POS_ADDR_17-1] = named_sync[5];
    ring_image[`MBST_POS_ADDR_16-1] = named_sync[6];
    ring_image[`MBST_POS_ADDR_18-1] = named_sync[7];
    ring_image[`MBST_POS_ADDR_15-1] = named_sync[8];
    // Unused cells stay in the chain but capture a steady low.
    ring_image = ring_image & ~unused_mask;
  end

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------

  reg [`MBST_BSR_W-1:0] bsr_shift;
  reg [`MBST_BSR_W-1:0] bsr_hold;
  reg [`MBST_ID_W-1:0] id_shift;
  reg bypass_bit;

  // Only the selected register captures and shifts, so the others keep their content.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      bsr_shift <= {`MBST_BSR_W{1'b0}};
      bsr_hold <= {`MBST_BSR_W{1'b0}};
      id_shift <= {`MBST_ID_W{1'b0}};
      bypass_bit <= 1'b0;
    end else if (tck_rise) begin
      if (st_cap_dr) begin
        if (sel_bsr) begin
          bsr_shift <= ring_image;
        end else if (sel_id) begin
          id_shift <= id_value;
        end else begin
          bypass_bit <= 1'b0;
        end
      end else if (st_sh_dr) begin
        if (sel_bsr) begin
          bsr_shift <= {jtag_sync[0], bsr_shift[`MBST_BSR_W-1:1]};
        end else if (sel_id) begin
          id_shift <= {jtag_sync[0], id_shift[`MBST_ID_W-1:1]};
        end else begin
          bypass_bit <= jtag_sync[0];
        end
      end else if (st_upd_dr && sel_bsr) begin
        bsr_hold <= bsr_shift;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------

  reg shifting;
  reg next_tdo;

  // Pick the least significant bit of the register that sits on the path.
  always @* begin
    if (st_sh_ir) begin
      next_tdo = ir_shift[0];
    end else if (sel_bsr) begin
      next_tdo = bsr_shift[0];
    end else if (sel_id) begin
      next_tdo = id_shift[0];
    end else begin
      next_tdo = bypass_bit;
    end
  end

  // Output changes on the falling test clock edge so the controller samples a settled bit.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      tdo_o <= 1'b0;
      shifting <= 1'b0;
    end else if (tck_fall) begin
      tdo_o <= next_tdo;
      shifting <= st_sh_dr | st_sh_ir;
    end
  end

  // The data-out ball is driven only while a register is shifting.
  assign tdo_oe_n_o = ~shifting;

  // ----------------------------------------------------------------
  // Ring control
  // ----------------------------------------------------------------

  // Ring controls are registered; normal operation is untouched outside clamp and high-Z.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      ring_drive_o <= {`MBST_BSR_W{1'b0}};
      ring_from_scan_o <= 1'b0;
      outputs_hiz_o <= 1'b0;
    end else begin
      ring_drive_o <= bsr_hold & ~unused_mask;
      ring_from_scan_o <= next_from_scan;
      outputs_hiz_o <= next_hiz;
    end
  end

endmodule // mbst_tap

`default_nettype wire

/* mbst_tap_fsm.v */
// Test access port controller state machine, advanced once per test clock rising edge.
`timescale 1ns/1ps
`default_nettype none

module mbst_tap_fsm (
  input wire ref_clk_i,
  input wire reset_n_i,
  input wire step_i,
  input wire tms_i,
  output wire test_reset_o,
  output wire capture_dr_o,
  output wire shift_dr_o,
  output wire update_dr_o,
  output wire capture_ir_o,
  output wire shift_ir_o,
  output wire update_ir_o
);

  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_IDLE = 16'h0002;
  localparam [15:0] S_SEL_DR = 16'h0004;
  localparam [15:0] S_CAP_DR = 16'h0008;
  localparam [15:0] S_SH_DR = 16'h0010;
  localparam [15:0] S_EX1_DR = 16'h0020;
  localparam [15:0] S_PAU_DR = 16'h0040;
  localparam [15:0] S_EX2_DR = 16'h0080;
  localparam [15:0] S_UPD_DR = 16'h0100;
  localparam [15:0] S_SEL_IR = 16'h0200;
  localparam [15:0] S_CAP_IR = 16'h0400;
  localparam [15:0] S_SH_IR = 16'h0800;
  localparam [15:0] S_EX1_IR = 16'h1000;
  localparam [15:0] S_PAU_IR = 16'h2000;
  localparam [15:0] S_EX2_IR = 16'h4000;
  localparam [15:0] S_UPD_IR = 16'h8000;

  reg [15:0] state;
  reg [15:0] next_state;

  // Standard transitions, chosen by the test mode select level.
  always @* begin
    case (state)
      S_TLR: next_state = tms_i ? S_TLR : S_IDLE;
      S_IDLE: next_state = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_DR: next_state = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_i ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: next_state = tms_i ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: next_state = tms_i ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms_i ? S_SEL_DR : S_IDLE;
      S_SEL_IR: next_state = tms_i ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_i ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: next_state = tms_i ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: next_state = tms_i ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms_i ? S_SEL_DR : S_IDLE;
      default: next_state = S_TLR;
    endcase
  end

  // The state only moves on a test clock rising edge.
  always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state <= S_TLR;
    end else if (step_i) begin
      state <= next_state;
    end
  end

  assign test_reset_o = state[0];
  assign capture_dr_o = state[3];
  assign shift_dr_o = state[4];
  assign update_dr_o = state[8];
  assign capture_ir_o = state[10];
  assign shift_ir_o = state[11];
  assign update_ir_o = state[15];

endmodule // mbst_tap_fsm

`default_nettype wire

/* mbst_tap_monitor.sv */
// Concurrent checks on the ports of the memory boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_defines.vh"

module mbst_tap_monitor #(
  parameter [1:0] ORG = `MBST_ORG_X36
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic tck_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_n_o,
  input wire logic [`MBST_BSR_W-1:0] ring_drive_o,
  input wire logic ring_from_scan_o,
  input wire logic outputs_hiz_o,
  input wire logic [`MBST_IR_W-1:0] instruction_o
);
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  // Cells that must never be driven in this organisation.
  localparam [`MBST_BSR_W-1:0] UNUSED_MASK = (ORG == `MBST_ORG_X9) ? `MBST_UNUSED_X9 :
    (ORG == `MBST_ORG_X18) ? `MBST_UNUSED_X18 : `MBST_UNUSED_X36;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  sequence s_clamp_live;
    $past(instruction_o) == `MBST_OP_CLAMP;
  endsequence

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // The flags follow the live code one cycle late, in both directions.
  a_clamp_set: assert property (s_clamp_live |-> ring_from_scan_o)
    else $error("clamp flag missing");
  a_clamp_clear: assert property (ring_from_scan_o |-> s_clamp_live)
    else $error("clamp flag without clamp code");
  a_hiz_level: assert property (outputs_hiz_o == ($past(instruction_o) == `MBST_OP_HIGHZ))
    else $error("hiz flag wrong");
  a_normal_quiet: assert property (instruction_o inside {`MBST_OP_EXTEST, `MBST_OP_IDCODE, `MBST_OP_BYPASS}
    |=> !ring_from_scan_o && !outputs_hiz_o)
    else $error("normal operation disturbed");
  a_reset_idcode: assert property ($rose(reset_n_i) |-> instruction_o == `MBST_OP_IDCODE && tdo_oe_n_o)
    else $error("reset did not load identification");
  a_unused_cells_zero: assert property ((ring_drive_o & UNUSED_MASK) == '0)
    else $error("do-not-use cell driven");
  // Output data moves only in the low half of the test clock.
  a_tdo_on_fall: assert property ($changed(tdo_o) |-> !tck_i && !$past(tck_i, 2))
    else $error("tdo moved outside low phase");
  a_ir_on_rise: assert property ($changed(instruction_o) |-> tck_i)
    else $error("instruction changed off a rise");
  a_drive_on_rise: assert property ($changed(ring_drive_o) |-> tck_i)
    else $error("ring drive changed off a rise");
endmodule // mbst_tap_monitor
`default_nettype wire

/* mbst_tap_tb.sv */
// Self-checking testbench for the memory boundary-scan test port.
`timescale 1ns/1ps
`default_nettype none
`include "mbst_defines.vh"

module mbst_tap_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam [`MBST_BSR_W-1:0] UNUSED_MASK = `MBST_UNUSED_X18;
  localparam [31:0] ID_EXP = {2'h1, `MBST_ORG_X18, 2'b00, 2'h2, `MBST_IO_SEPARATE, `MBST_DENS_288,
    8'h5A, 11'h2A5, `MBST_ID_PRESENT};
  localparam [47:0] CODES = 48'h00_05_07_03_FF_21;
  localparam [105:0] BASE = {10'h2C5, {6{16'hA53C}}};
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [8:0] pins = 9'h15A;
  logic [112:0] ring = {1'b1, {7{16'h9C6B}}};
  logic [127:0] got;
  wire tck, tms, tdi, tdo, tdo_oe_n, clamp, hiz;
  wire [112:0] drive;
  wire [7:0] instr;
  int mismatches = 0;
  int checks = 0;

  always #2 ref_clk = ~ref_clk;

  // Identity values are arbitrary.
  mbst_tap #(.ORG(`MBST_ORG_X18), .DIE_REV(2'h1), .DENSITY(`MBST_DENS_288), .IO_TYPE(`MBST_IO_SEPARATE),
    .FAMILY_CODE(2'h2), .PART_CODE(8'h5A), .VENDOR_CODE(11'h2A5)) mbst_tap_i (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .write_data_clock_i(pins[0]), .write_data_clock_n_i(pins[1]),
    .chip_select_n_i(pins[2]), .refresh_n_i(pins[3]), .write_enable_n_i(pins[4]),
    .address_in_17_i(pins[5]), .address_in_16_i(pins[6]), .address_in_18_i(pins[7]),
    .address_in_15_i(pins[8]), .ring_in_i(ring), .ring_drive_o(drive), .ring_from_scan_o(clamp),
    .outputs_hiz_o(hiz), .instruction_o(instr));

  mbst_ctl_model mbst_ctl_model_i (.ref_clk_i(ref_clk), .tdo_i(tdo), .tdo_oe_n_i(tdo_oe_n),
    .tck_o(tck), .tms_o(tms), .tdi_o(tdi));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic cmp(input logic [127:0] g, input logic [127:0] e, input string m);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  task automatic test_reset_id();
    cmp(instr, 8'h21, "reset ir");
    cmp({clamp, hiz}, 2'b00, "reset flags");
    mbst_ctl_model_i.walk(6, 8'h1F);
    mbst_ctl_model_i.dr(32, 128'h0, got);
    cmp(got[31:0], ID_EXP, "id word");
    cmp(got[0], 1'b1, "id present");
    $display("test_reset_id done");
  endtask

  // Each of the six defined codes, then 114 bits through whatever it selects: the extra bit shows the length.
  task automatic test_codes();
    logic [7:0] code;
    logic [113:0] din;
    logic [113:0] exp;
    logic [112:0] cap;
    logic [112:0] last;
    last = drive;
    for (int k = 0; k < 6; k++) begin
      code = CODES[47 - 8 * k -: 8];
      ring <= {ring[111:0], ring[112]};
      pins <= {pins[7:0], pins[8]};
      mbst_ctl_model_i.ir(code, got);
      cmp(got[7:0], `MBST_IR_CAPTURE, "ir capture");
      cmp(instr, code, "live code");
      cmp(clamp, code == `MBST_OP_CLAMP, "clamp");
      cmp(hiz, code == `MBST_OP_HIGHZ, "hiz");
      din = {BASE, code};
      cap = {ring[112:9], pins} & ~UNUSED_MASK;
      mbst_ctl_model_i.dr(114, din, got);
      case (code)
        `MBST_OP_EXTEST, `MBST_OP_SAMPLE: exp = {din[0], cap};
        `MBST_OP_IDCODE: exp = {din[81:0], ID_EXP};
        default: exp = {din[112:0], 1'b0};
      endcase
      cmp(got[113:0], exp, "chain out");
      if (code == `MBST_OP_EXTEST || code == `MBST_OP_SAMPLE)
        last = din[113:1] & ~UNUSED_MASK;
      cmp(drive, last, "ring drive");
    end
    $display("test_codes done");
  endtask

  // Both a hard reset and five TMS highs restore identification.
  task automatic test_reset_again();
    mbst_ctl_model_i.ir(8'hFF, got);
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    cmp(instr, 8'h21, "hard reset ir");
    cmp({drive, clamp, hiz}, 115'h0, "hard reset outputs");
    mbst_ctl_model_i.walk(1, 8'h00);
    mbst_ctl_model_i.ir(8'h00, got);
    cmp(instr, 8'h00, "extest live");
    mbst_ctl_model_i.walk(6, 8'h1F);
    cmp(instr, 8'h21, "tap reset ir");
    $display("test_reset_again done");
  endtask

  // The run needs about 60 us; this cuts a hang.
  initial begin
    #300000;
    mismatches++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    test_reset_id();
    test_codes();
    test_reset_again();
    stop_test();
  end
endmodule // mbst_tap_tb

bind mbst_tap mbst_tap_monitor #(.ORG(ORG)) mbst_tap_monitor_i (.ref_clk_i, .reset_n_i, .tck_i, .tdo_o,
  .tdo_oe_n_o, .ring_drive_o, .ring_from_scan_o, .outputs_hiz_o, .instruction_o);
`default_nettype wire
